// ===== src/fbp_regs.vh
// Constants for the flash burst pump controller.
// Assumes inclusion by bare name from design files under src/.
`ifndef FBP_REGS_VH
`define FBP_REGS_VH

`define FBP_ROW_BITS 6
`define FBP_ROW_BYTES 64
`define FBP_CMD_PROGRAM 2'h0
`define FBP_CMD_ERASE 2'h1
`define FBP_CMD_BURST 2'h2
`define FBP_PUMP_RAMP_NS 500
`define FBP_CLK_NS 100
`define FBP_PUMP_RAMP_CYC ((`FBP_PUMP_RAMP_NS + `FBP_CLK_NS - 1) / `FBP_CLK_NS)

`endif

// ===== src/fbp_fifo.v
// Small command queue, flip-flop storage, valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none
module fbp_fifo #(
	parameter WIDTH = 18,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clock,
	input wire rstn,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr;
	reg [AW-1:0] rdPtr;
	reg [AW:0] count;
	wire push;
	wire pop;
	reg [AW:0] next_count;
	reg notFull;
	integer i;

	// Registered so the ready port comes straight from a flip-flop
	assign inReady = notFull;
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData = mem[rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always @* begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			notFull <= 1'b1;
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem[i] <= {WIDTH{1'b0}};
			end
		end else begin
			if (push) begin
				mem[wrPtr] <= inData;
				wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: rdPtr + 1'b1;
			end
			count <= next_count;
			notFull <= (next_count != DEPTH[AW:0]);
		end
	end
endmodule // fbp_fifo
`default_nettype wire

// ===== src/fbp_pump_ctrl.v
// Charge pump sequencer for flash program, erase and burst program.
// Assumes commands arrive synchronous to clock; the array reports done.
`include "fbp_regs.vh"
`default_nettype none
module fbp_pump_ctrl #(
	parameter ADDR_W = 16,
	parameter DEPTH = 4,
	parameter RAMP_CYC = `FBP_PUMP_RAMP_CYC
) (
	input wire clock,
	input wire rstn,
	input wire cmdValid,
	output wire cmdReady,
	input wire [1:0] cmdKind,
	input wire [ADDR_W-1:0] cmdAddr,
	input wire [7:0] cmdData,
	input wire arrayDone,
	output reg pumpOn,
	output reg arrayStart,
	output reg [1:0] arrayKind,
	output reg [ADDR_W-1:0] arrayAddr,
	output reg [7:0] arrayData,
	output reg busy,
	output reg burstChained
);
	localparam W = ADDR_W + 10;
	localparam S_IDLE = 2'h0;
	localparam S_RAMP = 2'h1;
	localparam S_RUN = 2'h2;
	localparam RAMP_W = 8;

	reg [1:0] state;
	reg [RAMP_W-1:0] rampCnt;
	reg queuedEarly;
	reg [1:0] next_state;
	reg [RAMP_W-1:0] next_rampCnt;
	reg next_queuedEarly;
	reg next_pumpOn;
	reg next_arrayStart;
	reg [1:0] next_arrayKind;
	reg [ADDR_W-1:0] next_arrayAddr;
	reg [7:0] next_arrayData;
	reg next_busy;
	reg next_burstChained;
	wire isBurstNow;
	wire headIsBurst;
	wire headIsNext;
	wire rampDone;
	wire doneChain;
	wire doneEnd;
	wire qValid;
	wire qReady;
	wire [W-1:0] qData;
	wire [1:0] qKind;
	wire [ADDR_W-1:0] qAddr;
	wire [7:0] qData8;
	wire [ADDR_W-1:0] nextAddr;
	wire sameRow;
	wire chainOk;
	wire startFresh;

	fbp_fifo #(
		.WIDTH(W),
		.DEPTH(DEPTH),
		.AW(2)
	) cmdQueue (
		.clock(clock),
		.rstn(rstn),
		.inValid(cmdValid),
		.inReady(cmdReady),
		.inData({cmdKind, cmdAddr, cmdData}),
		.outValid(qValid),
		.outReady(qReady),
		.outData(qData)
	);

	assign qKind = qData[W-1:W-2];
	assign qAddr = qData[W-3:8];
	assign qData8 = qData[7:0];
	// Following byte of the current burst
	assign nextAddr = arrayAddr + {{(ADDR_W-1){1'b0}}, 1'b1};
	// Low bits all zero mark a new row, so continuity stops there
	assign sameRow = (nextAddr[`FBP_ROW_BITS-1:0] != 6'h0);
	assign isBurstNow = (arrayKind == `FBP_CMD_BURST);
	assign headIsBurst = qValid && (qKind == `FBP_CMD_BURST);
	// Only the sequential byte may ride on the running pump
	assign headIsNext = (qAddr == nextAddr);
	// Queued next burst must be the sequential byte in the same row
	assign chainOk = isBurstNow && queuedEarly && headIsBurst
		&& headIsNext && sameRow;
	assign rampDone = (rampCnt <= 8'h1);
	assign doneChain = (state == S_RUN) && arrayDone && chainOk;
	assign doneEnd = (state == S_RUN) && arrayDone && !chainOk;
	assign startFresh = (state == S_IDLE) && qValid;
	// Pop on accepting a fresh command or chaining directly
	assign qReady = startFresh || doneChain;

	// Next-state logic kept apart from the registers below
	always @* begin
		next_state = state;
		next_rampCnt = rampCnt;
		next_queuedEarly = queuedEarly;
		next_pumpOn = pumpOn;
		next_arrayStart = 1'b0;
		next_arrayKind = arrayKind;
		next_arrayAddr = arrayAddr;
		next_arrayData = arrayData;
		next_busy = busy;
		next_burstChained = 1'b0;
		case (state)
		S_IDLE: begin
			next_busy = 1'b0;
			if (qValid) begin
				next_arrayKind = qKind;
				next_arrayAddr = qAddr;
				next_arrayData = qData8;
				next_pumpOn = 1'b1;
				next_rampCnt = RAMP_CYC[RAMP_W-1:0];
				next_busy = 1'b1;
				next_state = S_RAMP;
			end
		end
		S_RAMP: begin
			// Array waits until high voltage has settled
			if (rampDone) begin
				next_arrayStart = 1'b1;
				next_queuedEarly = 1'b0;
				next_state = S_RUN;
			end else begin
				next_rampCnt = rampCnt - 8'h1;
			end
		end
		S_RUN: begin
			// A command seen before done counts as queued in time
			if (qValid && !arrayDone) begin
				next_queuedEarly = 1'b1;
			end
			if (doneChain) begin
				next_queuedEarly = 1'b0;
				next_arrayAddr = qAddr;
				next_arrayData = qData8;
				next_arrayStart = 1'b1;
				next_burstChained = 1'b1;
			end else if (doneEnd) begin
				// Ordinary end or broken burst drops the pump
				next_queuedEarly = 1'b0;
				next_pumpOn = 1'b0;
				next_busy = 1'b0;
				next_state = S_IDLE;
			end
		end
		default: begin
			next_state = S_IDLE;
			next_pumpOn = 1'b0;
			next_busy = 1'b0;
		end
		endcase
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= S_IDLE;
			rampCnt <= {RAMP_W{1'b0}};
			queuedEarly <= 1'b0;
			pumpOn <= 1'b0;
			arrayStart <= 1'b0;
			arrayKind <= 2'h0;
			arrayAddr <= {ADDR_W{1'b0}};
			arrayData <= 8'h0;
			busy <= 1'b0;
			burstChained <= 1'b0;
		end else begin
			state <= next_state;
			rampCnt <= next_rampCnt;
			queuedEarly <= next_queuedEarly;
			pumpOn <= next_pumpOn;
			arrayStart <= next_arrayStart;
			arrayKind <= next_arrayKind;
			arrayAddr <= next_arrayAddr;
			arrayData <= next_arrayData;
			busy <= next_busy;
			burstChained <= next_burstChained;
		end
	end
endmodule // fbp_pump_ctrl
`default_nettype wire

// ===== tb/fbp_array_model.sv
// Flash array stand-in: answers each start with a done pulse.
// Assumes lat is at least one; tb sets it to model slow or quick rows.
`default_nettype none
module fbp_array_model (
	input wire logic clock,
	input wire logic rstn,
	input wire logic arrayStart,
	input wire logic [3:0] lat,
	output var logic arrayDone
);
	logic [3:0] cnt;
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt <= 4'h0;
			arrayDone <= 1'b0;
		end else begin
			arrayDone <= cnt == 4'h1;
			cnt <= arrayStart ? lat : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
		end
	end
endmodule // fbp_array_model
`default_nettype wire

// ===== tb/fbp_pump_properties.sv
// Timing checks on pump, start and chain outputs of the sequencer.
// Assumes bind to fbp_pump_ctrl; RAMP_CYC matches the instance.
`include "fbp_regs.vh"
`default_nettype none
module fbp_pump_properties #(parameter int RAMP_CYC = 1) (
	input wire clock,
	input wire rstn,
	input wire arrayDone,
	input wire pumpOn,
	input wire arrayStart,
	input wire [1:0] arrayKind,
	input wire [15:0] arrayAddr,
	input wire burstChained
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	a_pump_before_start: assert property (arrayStart |-> pumpOn)
		else $error("start without pump");
	a_ramp_wait: assert property ($rose(pumpOn) |->
		!arrayStart ##RAMP_CYC arrayStart) else $error("ramp length wrong");
	a_start_pulse: assert property (arrayStart |=> !arrayStart)
		else $error("start longer than one cycle");
	a_off_after_done: assert property (arrayDone |=>
		burstChained || !pumpOn) else $error("pump left on");
	a_chain_after_burst: assert property (burstChained |->
		$past(arrayDone) && $past(arrayKind) == `FBP_CMD_BURST)
		else $error("chain without finished burst");
	a_chain_same_row: assert property (burstChained |->
		arrayAddr == $past(arrayAddr) + 16'h1 && arrayAddr[5:0] != 6'h0)
		else $error("chain across row");
	a_chain_no_ramp: assert property (burstChained |->
		arrayStart && $past(pumpOn)) else $error("chain not direct");
endmodule // fbp_pump_properties
bind fbp_pump_ctrl fbp_pump_properties #(.RAMP_CYC(RAMP_CYC)) u_chk (.clock,
	.rstn, .arrayDone, .pumpOn, .arrayStart, .arrayKind, .arrayAddr,
	.burstChained);
`default_nettype wire

// ===== tb/fbp_pump_ctrl_tb_top.sv
// Bench: program/erase, late burst, full queue of chained bursts.
// Assumes RAMP_CYC of one to keep the run short.
`include "fbp_regs.vh"
`default_nettype none
module fbp_pump_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rstn, cmdValid, cmdReady, arrayDone, pumpOn, arrayStart;
	logic busy, burstChained;
	logic [1:0] cmdKind;
	logic [15:0] cmdAddr;
	logic [7:0] cmdData;
	logic [3:0] lat;
	logic [15:0] arrAddr;
	logic [7:0] arrData;
	int nFail = 0, nTests = 0, nCh = 0, nRef = 0;
	fbp_pump_ctrl #(.RAMP_CYC(1)) i_dut (.clock, .rstn, .cmdValid,
		.cmdReady, .cmdKind, .cmdAddr, .cmdData, .arrayDone, .pumpOn,
		.arrayStart, .arrayKind(), .arrayAddr(arrAddr),
		.arrayData(arrData), .busy,
		.burstChained);
	fbp_array_model i_arr (.clock, .rstn, .arrayStart, .lat, .arrayDone);
	initial begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		nCh += burstChained;
		nRef += cmdValid && !cmdReady;
		// Bench sends data equal to the low address byte
		if (arrayStart) chk(arrData, arrAddr[7:0]);
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		nTests++;
		if (s !== e) begin
			nFail++;
			$display("MISMATCH %0t %h %h", $time, s, e);
		end
	endtask
	task close_out;
		if (nFail == 0 && nTests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Holds valid between calls, so back-to-back sends never re-raise it
	task send(input logic [1:0] k, input logic [15:0] a);
		cmdValid <= 1;
		cmdKind <= k;
		cmdAddr <= a;
		cmdData <= a[7:0];
		// Ready judged off the edge, so the accepting edge is certain
		@(negedge clock);
		while (cmdReady !== 1) @(negedge clock);
		@(posedge clock);
	endtask
	// Busy dips for one cycle between queued commands that are not chained
	task idle;
		int i, q;
		cmdValid <= 0;
		q = 0;
		for (i = 0; i < 300 && q < 3; i++) begin
			@(negedge clock);
			q = (busy === 0) ? q + 1 : 0;
		end
		chk(8'(q), 8'h3);
		chk(pumpOn, 0);
		@(posedge clock);
	endtask
	task t_plain;
		int c;
		c = nCh;
		lat <= 4'h3;
		send(`FBP_CMD_PROGRAM, 16'h10);
		send(`FBP_CMD_ERASE, 16'h11);
		idle;
		chk(8'(nCh - c), 0);
	endtask
	task t_late;
		int c;
		c = nCh;
		send(`FBP_CMD_BURST, 16'h20);
		idle;
		send(`FBP_CMD_BURST, 16'h21);
		idle;
		chk(8'(nCh - c), 0);
	endtask
	// Slow array lets the queue fill; 0x40 opens a new row
	task t_full;
		int c, r;
		logic [15:0] a;
		c = nCh;
		r = nRef;
		lat <= 4'hf;
		for (a = 16'h3b; a <= 16'h40; a++) send(`FBP_CMD_BURST, a);
		idle;
		chk(8'(nCh - c), 4);
		chk(nRef > r, 1);
	endtask
	initial begin
		rstn = 0;
		cmdValid = 0;
		cmdKind = 0;
		cmdAddr = 0;
		cmdData = 0;
		lat = 1;
		repeat (5) @(posedge clock);
		rstn <= 1;
		t_plain;
		t_late;
		t_full;
		close_out;
	end
	initial begin
		#500000;
		nFail++;
		close_out;
	end
endmodule // fbp_pump_ctrl_tb_top
`default_nettype wire
